// File: hw/doze_divider.sv
// cpu clock enable divider for doze mode
`include "power_save_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module doze_divider
  import power_save_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // control
  input  wire logic       doze_active,
  input  wire logic [2:0] ratio,
  // output
  output logic            cpu_enable
);
  typedef struct packed {
    logic [6:0] count;
  } div_s;

  div_s st;
  div_s next_st;

  // ratio code n gives divide by 2**n
  function automatic logic [6:0] last_count(input logic [2:0] code);
    last_count = 7'((8'h01 << code) - 8'h01);
  endfunction

  // count within the ratio; restart at once when doze drops
  always_comb begin
    next_st = st;
    if (!doze_active || st.count >= last_count(ratio)) begin
      next_st.count = 7'h00;
    end else begin
      next_st.count = st.count + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // enable pulse keeps cpu in step with system clock
  assign cpu_enable = !doze_active || (st.count == 7'h00);

  // at ratio 1, a cpu pulse every second cycle
  AST_DOZE_PERIOD: assert property (@(posedge clk) disable iff (!rst_b)
    doze_active && ratio == 3'h1 && cpu_enable
      |=> (!cpu_enable || !doze_active)
      ##1 (cpu_enable || !doze_active || ratio != 3'h1))
    else $error("doze 1:2 cadence broken");
endmodule
`default_nettype wire

// File: hw/power_save_cfg.svh
// constants for the power saving control block
`ifndef POWER_SAVE_CFG_SVH
`define POWER_SAVE_CFG_SVH

// register offsets
`define OFS_WAKE_CTRL    4'h0
`define OFS_IFLAG5       4'h1
`define OFS_RESET_CTRL   4'h2
`define OFS_CLK_DIV      4'h3
`define OFS_STATUS       4'h4
// field positions
`define BIT_WAKE_EN      15
`define BIT_WAKE_IDLE    13
`define BIT_SINK_EN      8
`define BIT_WAKE_FLAG    0
`define BIT_RET_EN       12
`define BIT_SLP_FULL     8
`define BIT_FULL_ON_INT  15
`define BIT_DOZE_HI      14
`define BIT_DOZE_LO      12
`define BIT_DOZE_EN      11
`define BIT_RET_FUSE     2
// writable masks (unimplemented bits read zero)
`define WAKE_CTRL_MASK   16'ha100
`define RESET_CTRL_MASK  16'h1100
`define CLK_DIV_MASK     16'hf800
// reset values
`define RESET_ZERO       16'h0000
// retention wake-up delay, in ns, and in cycles of the 100 ns clock
`define RET_WAKE_NS      2000
`define CLK_NS           100
`define RET_WAKE_CYC     ((`RET_WAKE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// File: hw/power_save_control.sv
// power saving control: sleep/idle, discharge wake, regulator select, doze
//
// Strobed register access and the address map were left to the implementer.
`include "power_save_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module power_save_control
  import power_save_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        por_event,
  // register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata,
  // cpu side
  input  wire logic        power_save_instruction,
  input  wire logic        idle_select,
  input  wire logic        irq,
  output logic             cpu_run,
  output logic             cpu_enable,
  output logic             irq_deliver,
  // fuse and pin
  input  wire logic        retention_config_fuse,
  input  wire logic        wake_pin_in,
  output logic             sink_on,
  // regulators
  output logic             main_reg_on,
  output logic             main_reg_standby,
  output logic             ret_reg_on,
  output logic             flash_powered
);
  typedef struct packed {
    pwr_state_e  state;
    logic        idle_req;
    logic        held_irq;
    logic        ret_sleep;
    logic [7:0]  wake_cnt;
    word_t       wake_ctrl;
    logic        wake_flag;
    word_t       reset_ctrl;
    word_t       clk_div;
    word_t       rdata;
  } core_s;

  localparam logic [7:0] RET_WAKE = 8'(`RET_WAKE_CYC);

  core_s st;
  core_s next_st;
  logic  in_sleep;
  logic  ret_on;
  logic  unit_live;
  logic  pin_wake;
  logic  any_reset;

  // write helper that keeps unimplemented bits at zero
  function automatic word_t masked(input word_t val, input word_t mask);
    masked = val & mask;
  endfunction

  assign any_reset = !rst_b || por_event;
  assign in_sleep  = (st.state == ST_SLEEP);

  assign unit_live = st.wake_ctrl[`BIT_WAKE_EN] &&
                     !(st.state == ST_IDLE && st.wake_ctrl[`BIT_WAKE_IDLE]);
  // wake when pin reads logic low
  assign pin_wake  = unit_live && in_sleep && !wake_pin_in;

  // main next-state logic
  always_comb begin
    next_st = st;
    next_st.rdata = 16'h0000;
    // register reads, data next cycle
    if (rd) begin
      unique case (addr)
        `OFS_WAKE_CTRL:  next_st.rdata = st.wake_ctrl;
        `OFS_IFLAG5:     next_st.rdata = {15'h0000, st.wake_flag};
        `OFS_RESET_CTRL: next_st.rdata = st.reset_ctrl;
        `OFS_CLK_DIV:    next_st.rdata = st.clk_div;
        `OFS_STATUS:     next_st.rdata = {11'h000, st.state};
        default:         next_st.rdata = 16'h0000;
      endcase
    end
    // register writes
    if (wr) begin
      unique case (addr)
        `OFS_WAKE_CTRL:  next_st.wake_ctrl  = masked(wdata, `WAKE_CTRL_MASK);
        `OFS_IFLAG5:     next_st.wake_flag  = wdata[`BIT_WAKE_FLAG];
        `OFS_RESET_CTRL: next_st.reset_ctrl = masked(wdata, `RESET_CTRL_MASK);
        `OFS_CLK_DIV:    next_st.clk_div    = masked(wdata, `CLK_DIV_MASK);
        default: ;
      endcase
    end
    if (irq && st.clk_div[`BIT_FULL_ON_INT] && st.clk_div[`BIT_DOZE_EN]) begin
      next_st.clk_div[`BIT_DOZE_EN] = 1'b0;
    end
    unique case (st.state)
      ST_RUN: begin
        if (power_save_instruction) begin
          next_st.state    = ST_ENTER;
          next_st.idle_req = idle_select;
          next_st.held_irq = irq;
        end
      end
      ST_ENTER: begin
        next_st.held_irq = st.held_irq || irq;
        next_st.state    = st.idle_req ? ST_IDLE : ST_SLEEP;
        next_st.ret_sleep = !st.idle_req && ret_on_sleep(st);
      end
      ST_SLEEP: begin
        // wake right after entry if held
        if (st.held_irq || irq || pin_wake) begin
          next_st.held_irq = 1'b0;
          next_st.wake_cnt = st.ret_sleep ? RET_WAKE : 8'h00;
          next_st.state    = ST_WAKE;
        end
        // flag set, wins over a clear
        if (pin_wake) begin
          next_st.wake_flag = 1'b1;
        end
      end
      ST_IDLE: begin
        if (st.held_irq || irq) begin
          next_st.held_irq = 1'b0;
          next_st.wake_cnt = 8'h00;
          next_st.state    = ST_WAKE;
        end
      end
      // wait for core supply before resume
      ST_WAKE: begin
        if (st.wake_cnt == 8'h00) begin
          next_st.state     = ST_RUN;
          next_st.ret_sleep = 1'b0;
        end else begin
          next_st.wake_cnt = st.wake_cnt - 8'h01;
        end
      end
    endcase
  end

  // retention sleep decision taken at entry
  function automatic logic ret_on_sleep(input core_s s);
    ret_on_sleep = !retention_config_fuse && s.reset_ctrl[`BIT_RET_EN] &&
                   !s.reset_ctrl[`BIT_SLP_FULL];
  endfunction

  // state register
  always_ff @(posedge clk) begin
    if (any_reset) begin
      st <= '{state: ST_RUN, wake_ctrl: `RESET_ZERO, reset_ctrl: `RESET_ZERO,
              clk_div: `RESET_ZERO, rdata: `RESET_ZERO, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign rdata       = st.rdata;
  assign cpu_run     = (st.state == ST_RUN);
  // resume after wake with next instruction
  assign irq_deliver = cpu_run && irq;
  assign sink_on     = st.wake_ctrl[`BIT_WAKE_EN] && st.wake_ctrl[`BIT_SINK_EN];

  regulator_select u_reg (
    .ret_fuse         (retention_config_fuse),
    .ret_en           (st.reset_ctrl[`BIT_RET_EN]),
    .slp_full         (st.reset_ctrl[`BIT_SLP_FULL]),
    .in_sleep         (in_sleep),
    .main_reg_on      (main_reg_on),
    .main_reg_standby (main_reg_standby),
    .ret_reg_on       (ret_on),
    .flash_powered    (flash_powered)
  );
  assign ret_reg_on = ret_on;

  logic doze_en;
  logic cpu_tick;
  // doze only while bit is set
  assign doze_en = st.clk_div[`BIT_DOZE_EN];

  doze_divider u_doze (
    .clk         (clk),
    .rst_b       (rst_b && !por_event),
    .doze_active (doze_en),
    .ratio       (st.clk_div[`BIT_DOZE_HI:`BIT_DOZE_LO]),
    .cpu_enable  (cpu_tick)
  );
  assign cpu_enable = cpu_run && cpu_tick;

  AST_ENTRY_HOLD: assert property (@(posedge clk) disable iff (any_reset)
    st.state == ST_RUN && power_save_instruction && irq
      |=> st.state == ST_ENTER ##1 (st.state == ST_SLEEP || st.state == ST_IDLE)
      ##1 st.state == ST_WAKE)
    else $error("held interrupt did not wake after entry");

  AST_POR_CLEAR: assert property (@(posedge clk)
    por_event |=> st.wake_ctrl == 16'h0000 && st.clk_div == 16'h0000 && cpu_run)
    else $error("power-on did not clear state");

  AST_PIN_WAKE: assert property (@(posedge clk) disable iff (any_reset)
    pin_wake |=> st.state == ST_WAKE)
    else $error("pin low did not wake");

  AST_WAKE_FLAG: assert property (@(posedge clk) disable iff (any_reset)
    pin_wake |=> st.wake_flag)
    else $error("wake flag not set");

  AST_ENABLE_OFF: assert property (@(posedge clk) disable iff (any_reset)
    !st.wake_ctrl[`BIT_WAKE_EN] |-> !pin_wake && !sink_on)
    else $error("disabled unit acted");

  AST_SINK: assert property (@(posedge clk) disable iff (any_reset)
    wr && addr == `OFS_WAKE_CTRL && wdata[15] && wdata[8] |=> sink_on)
    else $error("sink not enabled by write");

  AST_MASK: assert property (@(posedge clk) disable iff (any_reset)
    rd && addr == `OFS_WAKE_CTRL |=> (rdata & 16'h5eff) == 16'h0000)
    else $error("unimplemented bits read nonzero");

  AST_RET_FUSE: assert property (@(posedge clk) disable iff (any_reset)
    retention_config_fuse |-> !ret_reg_on)
    else $error("retention on with fuse high");

  AST_RET_WAKE: assert property (@(posedge clk) disable iff (any_reset)
    st.state == ST_SLEEP && st.ret_sleep && $changed(st.state) == 1'b0
      && next_st.state == ST_WAKE |=> !cpu_run [*8])
    else $error("retention wake too short");

  AST_ROI: assert property (@(posedge clk) disable iff (any_reset)
    irq && st.clk_div[15] && st.clk_div[11] && !wr |=> !st.clk_div[11])
    else $error("interrupt did not end doze");
endmodule
`default_nettype wire

// File: hw/power_save_pkg.sv
// types shared by the power saving control block
package power_save_pkg;
  // power state, one-hot
  typedef enum logic [4:0] {
    ST_RUN   = 5'b00001,
    ST_ENTER = 5'b00010,
    ST_SLEEP = 5'b00100,
    ST_IDLE  = 5'b01000,
    ST_WAKE  = 5'b10000
  } pwr_state_e;
  typedef logic [15:0] word_t;
endpackage

// File: hw/regulator_select.sv
// sleep regulator selection
`include "power_save_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module regulator_select
  import power_save_pkg::*;
(
  // configuration
  input  wire logic ret_fuse,
  input  wire logic ret_en,
  input  wire logic slp_full,
  input  wire logic in_sleep,
  // regulator controls
  output logic      main_reg_on,
  output logic      main_reg_standby,
  output logic      ret_reg_on,
  output logic      flash_powered
);
  logic ret_allowed;

  // fuse programmed low and enable set
  // fuse high blocks retention for good
  assign ret_allowed = !ret_fuse && ret_en;

  // main off, retention only, in retention sleep
  assign ret_reg_on  = ret_allowed && !slp_full && in_sleep;
  assign main_reg_on = !ret_reg_on;

  // full power holds regulator and flash in sleep
  assign main_reg_standby = in_sleep && !slp_full && !ret_allowed;
  assign flash_powered    = !in_sleep || slp_full;
endmodule
`default_nettype wire

// File: verif/power_save_control_tb_top.sv
// self-checking bench for the power saving control block
`include "power_save_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module power_save_control_tb_top;
  import power_save_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        por_event = 1'b0;
  logic [3:0]  addr = 4'h0;
  word_t       wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  word_t       rdata;
  logic        power_save_instruction = 1'b0;
  logic        idle_select = 1'b0;
  logic        irq = 1'b0;
  logic        retention_config_fuse = 1'b0;
  logic        charge = 1'b0;
  logic        wake_pin_in;
  logic        cpu_run;
  logic        cpu_enable;
  logic        irq_deliver;
  logic        sink_on;
  logic        main_reg_on;
  logic        main_reg_standby;
  logic        ret_reg_on;
  logic        flash_powered;
  word_t       exp_reg [0:15];
  word_t       msk [0:15];
  int          fail_count = 0;
  int          check_count = 0;
  int          seed;
  int          n;
  int          c;
  logic        rs;

  power_save_control power_save_control_i (.clk(clk), .rst_b(rst_b), .por_event(por_event),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .power_save_instruction(power_save_instruction), .idle_select(idle_select), .irq(irq),
    .cpu_run(cpu_run), .cpu_enable(cpu_enable), .irq_deliver(irq_deliver),
    .retention_config_fuse(retention_config_fuse), .wake_pin_in(wake_pin_in),
    .sink_on(sink_on), .main_reg_on(main_reg_on), .main_reg_standby(main_reg_standby),
    .ret_reg_on(ret_reg_on), .flash_powered(flash_powered));
  rc_wake_pin rc_wake_pin_i (.clk(clk), .charge(charge), .sink_on(sink_on), .pin(wake_pin_in));

  // 10 MHz clock
  always #50 clk = ~clk;

  // register model back to reset: status shows the run state only
  task model_reset();
    for (int i = 0; i < 16; i++) begin
      exp_reg[i] = 16'h0000;
      msk[i] = 16'h0000;
    end
    exp_reg[4] = 16'h0001;
    msk[0] = `WAKE_CTRL_MASK;
    msk[1] = 16'h0001;
    msk[2] = `RESET_CTRL_MASK;
    msk[3] = `CLK_DIV_MASK;
  endtask

  task check(input string name, input word_t e, input word_t g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask

  task wr_reg(input logic [3:0] a, input word_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    exp_reg[a] = d & msk[a];
  endtask

  // read data stands only in the cycle after the strobe
  task rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check("rdata", exp_reg[a], rdata);
  endtask

  task enter(input logic idle);
    @(posedge clk);
    power_save_instruction <= 1'b1;
    idle_select <= idle;
    @(posedge clk);
    power_save_instruction <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // bounded wait for the cpu to run again
  task wait_run();
    n = 0;
    while (cpu_run !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // watchdog, well beyond the roughly 2600 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  // main sequence
  initial begin
    seed = 32'he600;
    model_reset();
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 8; a++) rd_reg(a[3:0]);
    for (int i = 0; i < 16; i++) begin
      wr_reg(i[3:0] % 4'h4, $random(seed));
      rd_reg(i[3:0] % 4'h4);
      check("sink_on", {15'h0, exp_reg[0][15] & exp_reg[0][8]}, {15'h0, sink_on});
    end
    wr_reg(4'h9, $random(seed));
    rd_reg(4'h9);
    wr_reg(4'h2, 16'hffff);
    @(posedge clk);
    por_event <= 1'b1;
    @(posedge clk);
    por_event <= 1'b0;
    model_reset();
    for (int a = 0; a < 5; a++) rd_reg(a[3:0]);
    // charge, release, arm unit and sink, then sleep
    @(posedge clk);
    charge <= 1'b1;
    @(posedge clk);
    charge <= 1'b0;
    wr_reg(4'h0, 16'h8100);
    enter(1'b0);
    check("cpu_run", 16'h0, {15'h0, cpu_run});
    wait_run();
    check("pin_wake", 16'h1, {15'h0, n > 15 && n < 100});
    exp_reg[1] = 16'h0001;
    rd_reg(4'h1);
    wr_reg(4'h0, 16'h0000);
    wr_reg(4'h1, 16'h0000);
    rd_reg(4'h1);
    // every fuse, retention enable and full power combination
    for (int k = 0; k < 8; k++) begin
      rs = !k[2] && k[1] && !k[0];
      @(posedge clk);
      retention_config_fuse <= k[2];
      wr_reg(4'h2, {3'h0, k[1], 3'h0, k[0], 8'h00});
      enter(1'b0);
      check("main_reg_on", {15'h0, !rs}, {15'h0, main_reg_on});
      check("standby", {15'h0, !k[0] && !rs}, {15'h0, main_reg_standby});
      check("flash", {15'h0, k[0]}, {15'h0, flash_powered});
      if (!(k[1] && k[0])) check("ret_reg_on", {15'h0, rs}, {15'h0, ret_reg_on});
      @(posedge clk);
      irq <= 1'b1;
      wait_run();
      check("long_wake", {15'h0, rs}, {15'h0, n >= 20 && n < 100});
      check("main_on_run", 16'h1, {15'h0, main_reg_on});
      @(posedge clk);
      irq <= 1'b0;
    end
    // interrupt together with the power save instruction
    @(posedge clk);
    power_save_instruction <= 1'b1;
    idle_select <= 1'b1;
    irq <= 1'b1;
    @(posedge clk);
    power_save_instruction <= 1'b0;
    @(posedge clk);
    #1;
    check("entry_done", 16'h0, {15'h0, cpu_run | irq_deliver});
    wait_run();
    check("rewake", 16'h1, {15'h0, n < 100});
    @(posedge clk);
    irq <= 1'b0;
    // every doze ratio, then doze off
    for (int r = 0; r < 9; r++) begin
      wr_reg(4'h3, (r < 8) ? {1'b0, r[2:0], 1'b1, 11'h000} : 16'h7000);
      c = 0;
      repeat (256) begin
        @(posedge clk);
        #1;
        if (cpu_enable === 1'b1) c++;
      end
      check("cpu_enable_count", (r < 8) ? (16'h0100 >> r) : 16'h0100, c[15:0]);
    end
    // interrupt with and without return to full speed
    for (int f = 1; f >= 0; f--) begin
      wr_reg(4'h3, {f[0], 15'h3800});
      @(posedge clk);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      if (f == 1) exp_reg[3] = 16'hb000;
      rd_reg(4'h3);
    end
    end_sim();
  end
endmodule
`default_nettype wire

// File: verif/rc_wake_pin.sv
// external rc network on the wake pin, charged by the port, drained by the sink
`timescale 1ns/1ps
`default_nettype none
module rc_wake_pin #(
  parameter int FULL_CYC = 40
) (
  // clock
  input  wire logic clk,
  // pin drivers
  input  wire logic charge,
  input  wire logic sink_on,
  // digital level seen by the device
  output logic      pin
);
  int level = 0;
  // charge then sink
  // no leakage modelled, so a disabled sink holds the charge forever
  always @(posedge clk) begin
    if (charge) begin
      level <= FULL_CYC;
    end else if (sink_on && level > 0) begin
      level <= level - 1;
    end
  end
  assign pin = (level > FULL_CYC / 2);
endmodule
`default_nettype wire
